/* rtl/dmacs_channel.sv */
// control and status logic of one dma channel: enable trigger, transfer end
// flag, interrupt request, request sampling, acknowledge timing and idle delay
// assumes a classic wishbone master on clk_i and a count unit on the same clock
//
// The Wishbone slave port was decided locally.
`default_nettype none
module dmacs_channel
    import dmacs_pkg::*;
#(
    parameter int DLY_CYC = DMACS_IDLE_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // io device pins
    input wire logic transfer_request_n_i,
    output logic transfer_acknowledge_out_o,
    // count unit on the same clock
    input wire logic count_zero_i,
    output logic xfer_done_o,
    // interrupt request
    output logic irq_o
);
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [15:0] prim_cfg_r, prim_cfg_nxt;
    logic [15:0] sec_r, sec_nxt;
    logic en_r, en_nxt;
    logic end_r, end_nxt;
    logic req_meta_r, req_sync_r, req_prev_r;
    logic pend_r, pend_nxt;
    dmacs_state_t state_r, state_nxt;
    logic [7:0] dly_r, dly_nxt;
    logic bus_req, hit_prim, hit_sec, wr_fire, wr_prim, wr_sec;
    logic fall_edge, edge_mode, can_start, start;
    logic [15:0] prim_rd, wmask;
    dmacs_sec_t sec;

    assign sec = '{idle_dly: sec_r[DMACS_IDLE_DLY_BIT], ack_mode: sec_r[DMACS_ACK_MODE_BIT],
                   ack_level: sec_r[DMACS_ACK_LEVEL_BIT]};
    assign bus_req = cyc_i && stb_i;
    assign hit_prim = adr_i[15:2] == DMACS_PRIM_IDX;
    assign hit_sec = adr_i[15:2] == DMACS_SEC_IDX;
    // a write takes effect on the edge where the master sees ack
    assign wr_fire = bus_req && we_i && ack_r;
    assign wr_prim = wr_fire && hit_prim;
    assign wr_sec = wr_fire && hit_sec;
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    assign prim_rd = prim_cfg_r | {14'h0000, end_r, en_r};

    // bus slave: one wait state, unmapped reads return zero
    always_comb begin
        ack_nxt = bus_req && !ack_r;
        dat_nxt = dat_r;
        if (ack_nxt) begin
            if (hit_prim) begin
                dat_nxt = {16'h0000, prim_rd};
            end else if (hit_sec) begin
                dat_nxt = {16'h0000, sec_r & DMACS_SEC_MASK};
            end else begin
                dat_nxt = 32'h0000_0000;
            end
        end
    end

    // control and status bits
    always_comb begin
        prim_cfg_nxt = prim_cfg_r;
        sec_nxt = sec_r;
        en_nxt = en_r;
        end_nxt = end_r;
        if (wr_prim) begin
            prim_cfg_nxt = (prim_cfg_r & ~(wmask & DMACS_PRIM_CFG_MASK))
                         | (dat_i[15:0] & wmask & DMACS_PRIM_CFG_MASK);
            if (sel_i[0] && !dat_i[DMACS_END_BIT]) begin
                end_nxt = 1'b0;
            end
            // writing zero to enable is ignored
            if (sel_i[0] && dat_i[DMACS_EN_BIT] && !end_r) begin
                en_nxt = 1'b1;
            end
        end
        if (wr_sec) begin
            sec_nxt = (sec_r & ~(wmask & DMACS_SEC_MASK)) | (dat_i[15:0] & wmask & DMACS_SEC_MASK);
        end
        // count zero wins over a clearing write in the same cycle
        if (count_zero_i) begin
            end_nxt = 1'b1;
            en_nxt = 1'b0;
        end
    end

    // irq_o from the end flag, gated by its enable
    assign irq_o = end_r && prim_cfg_r[DMACS_IRQ_EN_BIT];

    // request sampling and transfer sequencing
    assign edge_mode = prim_cfg_r[DMACS_REQ_EDGE_BIT];
    assign fall_edge = req_prev_r && !req_sync_r;
    assign can_start = en_r && !end_r && !count_zero_i;
    assign start = (state_r == DMACS_ST_IDLE) && can_start
                && (edge_mode ? pend_r : !req_sync_r);

    always_comb begin
        state_nxt = state_r;
        dly_nxt = dly_r;
        // edge seen while busy is kept; a new edge wins over consumption
        pend_nxt = fall_edge ? 1'b1 : (start ? 1'b0 : pend_r);
        unique case (state_r)
            DMACS_ST_IDLE: begin
                if (start) begin
                    state_nxt = DMACS_ST_READ;
                end
            end
            DMACS_ST_READ: begin
                state_nxt = DMACS_ST_WRITE;
            end
            DMACS_ST_WRITE: begin
                if (sec.idle_dly) begin
                    state_nxt = DMACS_ST_DELAY;
                    dly_nxt = 8'(DLY_CYC - 1);
                end else begin
                    state_nxt = DMACS_ST_IDLE;
                end
            end
            DMACS_ST_DELAY: begin
                if (dly_r == 8'h00) begin
                    state_nxt = DMACS_ST_IDLE;
                end else begin
                    dly_nxt = dly_r - 8'h01;
                end
            end
        endcase
    end

    assign xfer_done_o = state_r == DMACS_ST_WRITE;
    // ack is combinational from the phase so polarity changes take effect at once
    assign transfer_acknowledge_out_o =
        (sec.ack_mode ? (state_r == DMACS_ST_WRITE) : (state_r == DMACS_ST_READ))
        ~^ sec.ack_level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            prim_cfg_r <= DMACS_PRIM_RST;
            sec_r <= DMACS_SEC_RST;
            en_r <= 1'b0;
            end_r <= 1'b0;
            req_meta_r <= 1'b1;
            req_sync_r <= 1'b1;
            req_prev_r <= 1'b1;
            pend_r <= 1'b0;
            state_r <= DMACS_ST_IDLE;
            dly_r <= 8'h00;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            prim_cfg_r <= prim_cfg_nxt;
            sec_r <= sec_nxt;
            en_r <= en_nxt;
            end_r <= end_nxt;
            req_meta_r <= transfer_request_n_i;
            req_sync_r <= req_meta_r;
            req_prev_r <= req_sync_r;
            pend_r <= pend_nxt;
            state_r <= state_nxt;
            dly_r <= dly_nxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_irq_on_zero;
        count_zero_i && prim_cfg_r[DMACS_IRQ_EN_BIT] && !wr_prim |=> irq_o;
    endproperty
    a_irq_on_zero: assert property (p_irq_on_zero) else $error("irq not raised at zero");

    property p_irq_gated;
        !prim_cfg_r[DMACS_IRQ_EN_BIT] |-> !irq_o;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq while disabled");

    property p_end_set;
        count_zero_i |=> end_r && !en_r;
    endproperty
    a_end_set: assert property (p_end_set) else $error("end flag not set at zero");

    property p_no_start;
        end_r |=> state_r != DMACS_ST_READ;
    endproperty
    a_no_start: assert property (p_no_start) else $error("transfer with end flag set");

    property p_clear;
        wr_prim && sel_i[0] && !dat_i[DMACS_END_BIT] && !count_zero_i |=> !end_r;
    endproperty
    a_clear: assert property (p_clear) else $error("end flag not cleared");

    property p_en_read;
        ack_o && !we_i && hit_prim |-> dat_o[DMACS_EN_BIT] == $past(en_r);
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable read mismatch");

    property p_zero_write;
        wr_prim && !dat_i[DMACS_EN_BIT] && !count_zero_i |=> en_r == $past(en_r);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed enable");

    property p_trigger;
        wr_prim && sel_i[0] && dat_i[DMACS_EN_BIT] && !count_zero_i |=> en_r == !$past(end_r)
            || $past(en_r);
    endproperty
    a_trigger: assert property (p_trigger) else $error("enable trigger wrong");

    property p_idle_delay;
        state_r == DMACS_ST_WRITE && sec.idle_dly |=> state_r == DMACS_ST_DELAY;
    endproperty
    a_idle_delay: assert property (p_idle_delay) else $error("idle delay skipped");

    property p_ack_phase;
        state_r == DMACS_ST_READ && !sec.ack_mode
            |-> transfer_acknowledge_out_o == sec.ack_level ##1 state_r == DMACS_ST_WRITE
            && transfer_acknowledge_out_o == !sec.ack_level;
    endproperty
    a_ack_phase: assert property (p_ack_phase) else $error("ack timing wrong");

    property p_sec_nibble;
        ack_o && !we_i && hit_sec |-> dat_o[7:4] == 4'h0;
    endproperty
    a_sec_nibble: assert property (p_sec_nibble) else $error("reserved nibble nonzero");

    property p_level_req;
        state_r == DMACS_ST_IDLE && can_start && !edge_mode && !req_sync_r
            |=> state_r == DMACS_ST_READ;
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request not taken");

    property p_ack_wr;
        state_r == DMACS_ST_WRITE && sec.ack_mode
            |-> transfer_acknowledge_out_o == sec.ack_level;
    endproperty
    a_ack_wr: assert property (p_ack_wr) else $error("ack not active in write");

    property p_ack_idle;
        state_r == DMACS_ST_IDLE |-> transfer_acknowledge_out_o == !sec.ack_level;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack active while idle");

    property p_edge_wait;
        state_r == DMACS_ST_IDLE && edge_mode && !pend_r |=> state_r != DMACS_ST_READ;
    endproperty
    a_edge_wait: assert property (p_edge_wait) else $error("start without edge");

    property p_edge_take;
        state_r == DMACS_ST_IDLE && can_start && edge_mode && pend_r
            |=> state_r == DMACS_ST_READ;
    endproperty
    a_edge_take: assert property (p_edge_take) else $error("edge request not taken");

    property p_dly_load;
        state_r == DMACS_ST_WRITE && sec.idle_dly |=> dly_r == 8'(DLY_CYC - 1);
    endproperty
    a_dly_load: assert property (p_dly_load) else $error("idle delay length wrong");

    property p_dly_exit;
        state_r == DMACS_ST_DELAY && dly_r == 8'h00 |=> state_r == DMACS_ST_IDLE;
    endproperty
    a_dly_exit: assert property (p_dly_exit) else $error("idle delay overran");

    property p_no_dly;
        state_r == DMACS_ST_WRITE && !sec.idle_dly |=> state_r == DMACS_ST_IDLE;
    endproperty
    a_no_dly: assert property (p_no_dly) else $error("delay while disabled");

    property p_end_hold;
        end_r && !(wr_prim && sel_i[0] && !dat_i[DMACS_END_BIT]) |=> end_r;
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("end flag lost");

    property p_end_one;
        !end_r && wr_prim && dat_i[DMACS_END_BIT] && !count_zero_i |=> !end_r;
    endproperty
    a_end_one: assert property (p_end_one) else $error("write one set end flag");
endmodule
`default_nettype wire

/* rtl/dmacs_pkg.sv */
// constants and carrier types for the dma channel control and status block
// assumes a 10 MHz system clock and a 16-bit byte address on the register bus
`default_nettype none
package dmacs_pkg;
    // register indices; byte address is four times the index
    localparam logic [13:0] DMACS_PRIM_IDX = 14'h3c0c;
    localparam logic [13:0] DMACS_SEC_IDX = 14'h3c0e;
    // writable bit masks and reset values
    localparam logic [15:0] DMACS_PRIM_CFG_MASK = 16'hff5c;
    localparam logic [15:0] DMACS_SEC_MASK = 16'h000b;
    localparam logic [15:0] DMACS_PRIM_RST = 16'h0000;
    localparam logic [15:0] DMACS_SEC_RST = 16'h0000;
    // field positions, primary register
    localparam int DMACS_EN_BIT = 0;
    localparam int DMACS_END_BIT = 1;
    localparam int DMACS_IRQ_EN_BIT = 2;
    localparam int DMACS_REQ_EDGE_BIT = 6;
    // field positions, secondary register
    localparam int DMACS_ACK_LEVEL_BIT = 0;
    localparam int DMACS_ACK_MODE_BIT = 1;
    localparam int DMACS_IDLE_DLY_BIT = 3;
    // idle delay between accepted requests
    localparam int DMACS_CLK_PERIOD_NS = 100;
    localparam int DMACS_IDLE_DELAY_NS = 400;
    localparam int DMACS_IDLE_DELAY_CYC =
        (DMACS_IDLE_DELAY_NS + DMACS_CLK_PERIOD_NS - 1) / DMACS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DMACS_ST_IDLE,
        DMACS_ST_READ,
        DMACS_ST_WRITE,
        DMACS_ST_DELAY
    } dmacs_state_t;

    typedef struct packed {
        logic idle_dly;
        logic ack_mode;
        logic ack_level;
    } dmacs_sec_t;
endpackage
`default_nettype wire

/* tb/dmacs_channel_tb.sv */
// self-checking bench of the dma channel control and status block
// assumes the io model on the request pins and wishbone driven here
`default_nettype none
module dmacs_channel_tb
    import dmacs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] PRIM = 16'hf030;
    localparam logic [15:0] SEC = 16'hf038;
    localparam int DLY = 2;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, czero = 0, req_en = 0, hold = 0;
    logic lvl = 0, mode = 0, chk_ack = 0, ack, req_n, transfer_acknowledge_out, done, irq;
    logic [15:0] adr = 16'h0000, w;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat;
    int failures = 0, compares = 0, seed = 32'hab98, ndone = 0, tnow = 0, tlast = 0;
    int per = 0, p0, n0;

    dmacs_channel #(.DLY_CYC(DLY)) i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(dat),
        .ack_o(ack), .transfer_request_n_i(req_n), .transfer_acknowledge_out_o(transfer_acknowledge_out),
        .count_zero_i(czero), .xfer_done_o(done), .irq_o(irq));
    dmacs_io_model i_io (.clk_i(clk), .req_en_i(req_en), .hold_i(hold),
        .ack_level_i(lvl), .ack_i(transfer_acknowledge_out), .req_n_o(req_n));

    initial forever #50 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // expected primary read: stored bits plus the end flag and enable
    function automatic logic [15:0] prim_exp(input logic [15:0] wv, input logic ef,
        input logic nf);
        return (wv & DMACS_PRIM_CFG_MASK) | {14'h0000, ef, nf};
    endfunction
    // expected acknowledge pin in the read or write phase
    function automatic logic ack_exp(input logic m, input logic l, input logic wphase);
        return (m == wphase) ? l : !l;
    endfunction
    // waits for ack as long as it takes; only the watchdog ends a hung bus
    task automatic wb(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
        wb(1'b0, a, 16'h0000);
        chk(nm, rdat, {16'h0000, e});
    endtask
    task automatic zero_pulse;
        @(posedge clk);
        czero <= 1'b1;
        @(posedge clk);
        czero <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (done === 1'b1) begin
            ndone++;
            per = tnow - tlast;
            tlast = tnow;
            if (chk_ack) chk("ack_in_write", transfer_acknowledge_out, ack_exp(mode, lvl, 1'b1));
        end
        tnow++;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(PRIM, 16'h0000, "prim_reset");
        rd(SEC, 16'h0000, "sec_reset");
        wb(1'b1, SEC, 16'hffff);
        rd(SEC, 16'h000b, "sec_mask");
        rd(16'hf000, 16'h0000, "unmapped");
        repeat (4) begin
            w = 16'($random(seed));
            w[6] = 1'b0;
            w[2:0] = 3'b010;
            wb(1'b1, PRIM, w);
            rd(PRIM, prim_exp(w, 1'b0, 1'b0), "prim_rand");
        end
        lvl <= 1'b1;
        mode <= 1'b1;
        wb(1'b1, SEC, 16'h0003);
        wb(1'b1, PRIM, 16'h0005);
        rd(PRIM, 16'h0005, "enable_set");
        wb(1'b1, PRIM, 16'h0004);
        rd(PRIM, 16'h0005, "enable_write0");
        req_en <= 1'b1;
        chk_ack <= 1'b1;
        repeat (30) @(posedge clk);
        chk("level_repeats", 32'(ndone > 2), 32'h0000_0001);
        chk_ack <= 1'b0;
        hold <= 1'b1;
        repeat (20) @(posedge clk);
        p0 = per;
        lvl <= 1'b0;
        mode <= 1'b0;
        wb(1'b1, SEC, 16'h0008);
        repeat (30) @(posedge clk);
        chk("idle_gap", per - p0, DLY);
        chk_ack <= 1'b1;
        repeat (10) @(posedge clk);
        chk_ack <= 1'b0;
        zero_pulse;
        req_en <= 1'b0;
        repeat (10) @(posedge clk);
        chk("irq_set", irq, 1);
        rd(PRIM, 16'h0006, "end_set");
        n0 = ndone;
        wb(1'b1, PRIM, 16'h0007);
        req_en <= 1'b1;
        repeat (20) @(posedge clk);
        rd(PRIM, 16'h0006, "end_blocks");
        chk("no_xfer", ndone - n0, 0);
        req_en <= 1'b0;
        wb(1'b1, PRIM, 16'h0004);
        rd(PRIM, 16'h0004, "end_clear");
        chk("irq_clear", irq, 0);
        // an edge latched while the flag blocked is still pending; let it run first
        wb(1'b1, PRIM, 16'h0045);
        repeat (6) @(posedge clk);
        n0 = ndone;
        req_en <= 1'b1;
        repeat (30) @(posedge clk);
        chk("edge_once", ndone - n0, 1);
        req_en <= 1'b0;
        wb(1'b1, PRIM, 16'h0001);
        zero_pulse;
        repeat (2) @(posedge clk);
        chk("irq_masked", irq, 0);
        rd(PRIM, 16'h0002, "end_no_irq");
        end_of_test;
    end

    initial begin
        #2_000_000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire

/* tb/dmacs_io_model.sv */
// io device model: holds its request low and may drop it on acknowledge
// assumes the bench tells it the acknowledge polarity
`default_nettype none
module dmacs_io_model (
    // clock and control from the bench
    input wire logic clk_i,
    input wire logic req_en_i,
    input wire logic hold_i,
    input wire logic ack_level_i,
    // pins
    input wire logic ack_i,
    output logic req_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req_n_o = 1'b1;
    // released pin goes high, the request being active low
    always @(posedge clk_i) begin
        if (!req_en_i || (!hold_i && ack_i == ack_level_i)) begin
            req_n_o <= 1'b1;
        end else begin
            req_n_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire
